// ---- src/cvmr_pkg.sv ----
// command/address reference mode register: shared constants
// assumes one device clock; commands already decoded to write/read strobes
package cvmr_pkg;

	////////////////////////////////////////////////////////////////////////////
	// mode register address and field layout
	localparam logic [5:0] CVMR_REG_ADDR = 6'h0C;
	localparam int CVMR_LEVEL_LSB = 0;
	localparam int CVMR_LEVEL_MSB = 5;
	localparam int CVMR_RANGE_BIT = 6;
	localparam int CVMR_MODE_BIT = 7;
	localparam int CVMR_NUM_SP = 2;

	////////////////////////////////////////////////////////////////////////////
	// legal codes and reset values
	localparam logic [5:0] CVMR_LEVEL_MAX = 6'h32;
	localparam logic [5:0] CVMR_LEVEL_RST = 6'h0D;
	localparam logic CVMR_RANGE_RST = 1'b1;
	localparam logic CVMR_MODE_RST = 1'b0;
	localparam logic [7:0] CVMR_DQ_IDLE = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// reference level in tenths of a percent of the output supply
	localparam logic [9:0] CVMR_BASE_R0 = 10'h096;
	localparam logic [9:0] CVMR_BASE_R1 = 10'h149;
	localparam logic [3:0] CVMR_STEP = 4'h6;

	typedef logic [5:0] cvmr_level_t;
	typedef logic [9:0] cvmr_tenths_t;

endpackage : cvmr_pkg

// ---- src/cvmr_setpoint_copy.sv ----
// one set point's physical copy of the level and range fields
// assumes the parent gates wr_en by set point selection and code legality
`timescale 1ns/10ps
module cvmr_setpoint_copy (
	input wire logic clk,
	input wire logic reset,
	input wire logic wr_en,
	input wire cvmr_pkg::cvmr_level_t wr_level,
	input wire logic wr_range,
	output cvmr_pkg::cvmr_level_t level,
	output logic range
);
	import cvmr_pkg::*;

	cvmr_level_t level_r;
	logic range_r;
	cvmr_level_t level_nxt;
	logic range_nxt;

	// values hold until overwritten or reset
	assign level_nxt = wr_en ? wr_level : level_r;
	assign range_nxt = wr_en ? wr_range : range_r;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			level_r <= CVMR_LEVEL_RST;
			range_r <= CVMR_RANGE_RST;
		end else begin
			level_r <= level_nxt;
			range_r <= range_nxt;
		end
	end

	assign level = level_r;
	assign range = range_r;

endmodule : cvmr_setpoint_copy

// ---- src/cvmr_level_scale.sv ----
// maps level code and range to reference level in tenths of a percent
// assumes a legal code; purely combinational
`timescale 1ns/10ps
module cvmr_level_scale (
	input wire cvmr_pkg::cvmr_level_t level,
	input wire logic range,
	output cvmr_pkg::cvmr_tenths_t tenths
);
	import cvmr_pkg::*;

	cvmr_tenths_t base;
	cvmr_tenths_t offset;

	assign base = range ? CVMR_BASE_R1 : CVMR_BASE_R0;
	// widen before the product: a 6-bit product would wrap above code 10
	assign offset = 10'(level) * 10'(CVMR_STEP);
	assign tenths = 10'(base + offset);

endmodule : cvmr_level_scale

// ---- src/cvmr_top.sv ----
// command/address reference mode register with two frequency set points
// assumes write/read strobes from the command decoder on clk; set point
// selects come from the set point control register as plain levels
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Operation
// - level codes 0 through 0x32 are accepted, all higher codes are reserved.
// - bit 6 picks reference range 0 or 1, and range 1 is the reset default.
// - bit 7 picks training mode 1 (0, default) or mode 2 (1), on byte-mode parts only.
// - a read of this register drives register bits 7..0 onto data lines 7..0.
// - reserved bits and data lines without a register bit read as zero.
// - a level write lands in set point 0 when write-select is 0, else set point 1.
// - writing the range bit of the operate-selected copy moves the device between its two reference ranges.
// - a written range holds until overwritten or until reset.
// - each level and range bit has one copy per set point, reached by write-select.
// - the device runs only from the copy chosen by operate-select.
// - rewriting the inactive copy leaves the operating level and range unchanged; the single-copy mode bit 7 still takes the write.
// - level codes map to 15.0% plus 0.6% per step in range 0, 32.9% base in range 1.
// - write-select and operate-select are control bits 6 and 7, 0 meaning set point 0.
module cvmr_top (
	input wire logic clk,
	input wire logic reset,
	input wire logic mrw_valid,
	input wire logic [5:0] mrw_addr,
	input wire logic [7:0] mrw_data,
	input wire logic mrr_valid,
	input wire logic [5:0] mrr_addr,
	input wire logic setpoint_write_select,
	input wire logic setpoint_operate_select,
	input wire logic byte_mode,
	output logic [7:0] dq_out,
	output logic dq_oe,
	output logic mrw_refused,
	output cvmr_pkg::cvmr_level_t ca_reference_level,
	output logic ca_ref_range_select,
	output logic bus_training_mode_select,
	output cvmr_pkg::cvmr_tenths_t ca_reference_tenths
);
	import cvmr_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// command decode
	logic hit_wr;
	logic hit_rd;
	logic code_legal;
	logic wr_ok;
	cvmr_level_t wr_level;
	logic wr_range;
	logic wr_mode;

	assign hit_wr = mrw_valid && (mrw_addr == CVMR_REG_ADDR);
	assign hit_rd = mrr_valid && (mrr_addr == CVMR_REG_ADDR);
	assign wr_level = mrw_data[CVMR_LEVEL_MSB:CVMR_LEVEL_LSB];
	assign wr_range = mrw_data[CVMR_RANGE_BIT];
	assign wr_mode = mrw_data[CVMR_MODE_BIT];
	// a reserved code refuses the whole write so level and range stay paired
	assign code_legal = (wr_level <= CVMR_LEVEL_MAX);
	assign wr_ok = hit_wr && code_legal;

	////////////////////////////////////////////////////////////////////////////
	// byte-mode strap, caught after reset release
	logic strap_meta_r;
	logic strap_sync_r;
	logic strap_done_r;
	logic byte_mode_r;
	logic byte_mode_nxt;

	// the pin is not timed to clk; stages run through reset, so reset must last two clocks
	always_ff @(posedge clk) begin
		strap_meta_r <= byte_mode;
		strap_sync_r <= strap_meta_r;
	end

	assign byte_mode_nxt = strap_done_r ? byte_mode_r : strap_sync_r;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			strap_done_r <= 1'b0;
			byte_mode_r <= 1'b0;
		end else begin
			strap_done_r <= 1'b1;
			byte_mode_r <= byte_mode_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// per set point copies
	cvmr_level_t sp_level [CVMR_NUM_SP];
	logic sp_range [CVMR_NUM_SP];
	logic sp_wr_en [CVMR_NUM_SP];

	genvar g;
	generate
		for (g = 0; g < CVMR_NUM_SP; g++) begin : g_sp
			// only the copy named by write-select takes the write
			assign sp_wr_en[g] = wr_ok && (setpoint_write_select == 1'(g));
			cvmr_setpoint_copy u_copy (
				.clk(clk),
				.reset(reset),
				.wr_en(sp_wr_en[g]),
				.wr_level(wr_level),
				.wr_range(wr_range),
				.level(sp_level[g]),
				.range(sp_range[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// training mode select, single copy
	logic mode_r;
	logic mode_nxt;

	assign mode_nxt = wr_ok ? wr_mode : mode_r;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mode_r <= CVMR_MODE_RST;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// operating values from the active set point
	cvmr_level_t op_level;
	logic op_range;

	assign op_level = setpoint_operate_select ? sp_level[1] : sp_level[0];
	assign op_range = setpoint_operate_select ? sp_range[1] : sp_range[0];
	assign ca_reference_level = op_level;
	assign ca_ref_range_select = op_range;
	// mode 2 has no effect on non byte-mode parts
	assign bus_training_mode_select = mode_r && byte_mode_r;

	cvmr_level_scale u_scale (
		.level(op_level),
		.range(op_range),
		.tenths(ca_reference_tenths)
	);

	////////////////////////////////////////////////////////////////////////////
	// read path and refusal flag
	logic [7:0] rd_word;
	logic [7:0] dq_nxt;
	cvmr_level_t rd_level;
	logic rd_range;
	logic [7:0] dq_out_r;
	logic dq_oe_r;
	logic refused_r;

	assign rd_level = setpoint_write_select ? sp_level[1] : sp_level[0];
	assign rd_range = setpoint_write_select ? sp_range[1] : sp_range[0];
	assign rd_word = {mode_r, rd_range, rd_level};
	// lines idle at zero outside a read
	assign dq_nxt = hit_rd ? rd_word : CVMR_DQ_IDLE;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			dq_out_r <= CVMR_DQ_IDLE;
			dq_oe_r <= 1'b0;
			refused_r <= 1'b0;
		end else begin
			dq_out_r <= dq_nxt;
			dq_oe_r <= hit_rd;
			refused_r <= hit_wr && !code_legal;
		end
	end

	assign dq_out = dq_out_r;
	assign dq_oe = dq_oe_r;
	assign mrw_refused = refused_r;

	////////////////////////////////////////////////////////////////////////////
	// checks
	property p_reserved_code_kept;
		@(posedge clk) disable iff (reset)
		(hit_wr && (wr_level > CVMR_LEVEL_MAX)) |=>
			($stable(sp_level[0]) && $stable(sp_level[1]) && mrw_refused);
	endproperty
	a_reserved_code_kept: assert property (p_reserved_code_kept)
		else $error("reserved level code was stored");

	property p_write_sp0;
		@(posedge clk) disable iff (reset)
		(wr_ok && !setpoint_write_select) |=>
			(sp_level[0] == $past(wr_level)) && (sp_range[0] == $past(wr_range));
	endproperty
	a_write_sp0: assert property (p_write_sp0)
		else $error("write to set point 0 not stored");

	property p_write_sp1;
		@(posedge clk) disable iff (reset)
		(wr_ok && setpoint_write_select) |=>
			(sp_level[1] == $past(wr_level)) && (sp_range[1] == $past(wr_range));
	endproperty
	a_write_sp1: assert property (p_write_sp1)
		else $error("write to set point 1 not stored");

	property p_other_copy_kept;
		@(posedge clk) disable iff (reset)
		hit_wr |=> ($past(setpoint_write_select) ? $stable(sp_level[0]) && $stable(sp_range[0])
			: $stable(sp_level[1]) && $stable(sp_range[1]));
	endproperty
	a_other_copy_kept: assert property (p_other_copy_kept)
		else $error("write reached the unselected copy");

	property p_read_word;
		@(posedge clk) disable iff (reset)
		hit_rd |=> dq_oe && (dq_out == $past(rd_word));
	endproperty
	a_read_word: assert property (p_read_word)
		else $error("read did not return the selected copy");

	property p_idle_zero;
		@(posedge clk) disable iff (reset)
		!dq_oe |-> (dq_out == CVMR_DQ_IDLE);
	endproperty
	a_idle_zero: assert property (p_idle_zero)
		else $error("data lines not zero outside a read");

	property p_inactive_write_quiet;
		@(posedge clk) disable iff (reset)
		(wr_ok && (setpoint_write_select != setpoint_operate_select)
			##1 $stable(setpoint_operate_select)) |->
			$stable(ca_reference_level) && $stable(ca_ref_range_select);
	endproperty
	a_inactive_write_quiet: assert property (p_inactive_write_quiet)
		else $error("inactive set point write disturbed operation");

	property p_range_held;
		@(posedge clk) disable iff (reset)
		(!wr_ok ##1 $stable(setpoint_operate_select)) |-> $stable(ca_ref_range_select);
	endproperty
	a_range_held: assert property (p_range_held)
		else $error("range changed without a write");

	property p_mode_byte_only;
		@(posedge clk) disable iff (reset)
		!byte_mode_r |-> !bus_training_mode_select;
	endproperty
	a_mode_byte_only: assert property (p_mode_byte_only)
		else $error("training mode 2 active on non byte-mode part");

	property p_tenths;
		@(posedge clk) disable iff (reset)
		ca_reference_tenths == 10'((op_range ? 10'h149 : 10'h096) + 10'(op_level) * 10'h006);
	endproperty
	a_tenths: assert property (p_tenths)
		else $error("reference percentage mismatch");

	property p_refused_only_reserved;
		@(posedge clk) disable iff (reset)
		mrw_refused |-> $past(hit_wr) && ($past(wr_level) > CVMR_LEVEL_MAX);
	endproperty
	a_refused_only_reserved: assert property (p_refused_only_reserved)
		else $error("legal write flagged as refused");

	property p_active_write_seen;
		@(posedge clk) disable iff (reset)
		(wr_ok && (setpoint_write_select == setpoint_operate_select)
			##1 $stable(setpoint_operate_select)) |->
			(ca_reference_level == $past(wr_level)) && (ca_ref_range_select == $past(wr_range));
	endproperty
	a_active_write_seen: assert property (p_active_write_seen)
		else $error("write to the active set point not applied");

	property p_copy0_held;
		@(posedge clk) disable iff (reset)
		!(wr_ok && !setpoint_write_select) |=> $stable(sp_level[0]) && $stable(sp_range[0]);
	endproperty
	a_copy0_held: assert property (p_copy0_held)
		else $error("set point 0 changed without a write");

	property p_copy1_held;
		@(posedge clk) disable iff (reset)
		!(wr_ok && setpoint_write_select) |=> $stable(sp_level[1]) && $stable(sp_range[1]);
	endproperty
	a_copy1_held: assert property (p_copy1_held)
		else $error("set point 1 changed without a write");

	property p_mode_write;
		@(posedge clk) disable iff (reset)
		wr_ok |=> (mode_r == $past(wr_mode));
	endproperty
	a_mode_write: assert property (p_mode_write)
		else $error("training mode bit not stored");

	property p_strap_frozen;
		@(posedge clk) disable iff (reset)
		strap_done_r |=> $stable(byte_mode_r);
	endproperty
	a_strap_frozen: assert property (p_strap_frozen)
		else $error("byte-mode strap changed after capture");

	property p_read_miss_quiet;
		@(posedge clk) disable iff (reset)
		!hit_rd |=> !dq_oe;
	endproperty
	a_read_miss_quiet: assert property (p_read_miss_quiet)
		else $error("data lines enabled without a read");

endmodule : cvmr_top

// ---- bench/cvmr_ctrl_model.sv ----
// controller-side model: issues mode register write and read commands
// assumes the register takes a command at the rising clk edge
`timescale 1ns/10ps
module cvmr_ctrl_model (
	input wire logic clk,
	output logic mrw_valid,
	output logic [5:0] mrw_addr,
	output logic [7:0] mrw_data,
	output logic mrr_valid,
	output logic [5:0] mrr_addr
);
	initial begin
		mrw_valid = 1'b0;
		mrr_valid = 1'b0;
		mrw_addr = 6'h00;
		mrw_data = 8'h00;
		mrr_addr = 6'h00;
	end
	////////////////////////////////////////////////////////////////////////////
	// one slot per edge; idle lines toggle so stale values never look valid
	task automatic cmd(input logic w, input logic r, input logic [5:0] a, input logic [7:0] d);
		@(posedge clk);
		mrw_valid <= w;
		mrr_valid <= r;
		mrw_addr <= w ? a : ~mrw_addr;
		mrw_data <= w ? d : ~mrw_data;
		mrr_addr <= r ? a : ~mrr_addr;
	endtask : cmd
endmodule : cvmr_ctrl_model

// ---- bench/tb_ca_vref_mode_register.sv ----
// self-checking bench for the reference level mode register
// assumes the controller model drives commands; set point selects come from here
`timescale 1ns/10ps
module tb_ca_vref_mode_register;
	import cvmr_pkg::*;
	logic clk, reset, wsel, osel, byte_mode, bm_lat, mrw_valid, mrr_valid;
	logic [5:0] mrw_addr, mrr_addr;
	logic [7:0] mrw_data, dq_out;
	logic dq_oe, mrw_refused, rng_o, mode_o;
	cvmr_level_t lvl_o;
	cvmr_tenths_t tenths_o;
	int n_fail, samples_checked, n_ref;
	logic [7:0] q_rd[$];
	cvmr_level_t m_lvl[2];
	logic m_rng[2];
	logic m_mode;
	cvmr_ctrl_model ctrl_u (.clk(clk), .mrw_valid(mrw_valid), .mrw_addr(mrw_addr),
		.mrw_data(mrw_data), .mrr_valid(mrr_valid), .mrr_addr(mrr_addr));
	cvmr_top dut_u (.clk(clk), .reset(reset), .mrw_valid(mrw_valid), .mrw_addr(mrw_addr),
		.mrw_data(mrw_data), .mrr_valid(mrr_valid), .mrr_addr(mrr_addr),
		.setpoint_write_select(wsel), .setpoint_operate_select(osel),
		.byte_mode(byte_mode), .dq_out(dq_out), .dq_oe(dq_oe), .mrw_refused(mrw_refused),
		.ca_reference_level(lvl_o), .ca_ref_range_select(rng_o),
		.bus_training_mode_select(mode_o), .ca_reference_tenths(tenths_o));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report
	task automatic do_reset(input logic bm);
		// let the watcher drain the last answer before the notes are cleared
		@(posedge clk);
		reset <= 1'b1;
		byte_mode <= bm;
		bm_lat = bm;
		m_lvl = '{CVMR_LEVEL_RST, CVMR_LEVEL_RST};
		m_rng = '{CVMR_RANGE_RST, CVMR_RANGE_RST};
		m_mode = CVMR_MODE_RST;
		q_rd.delete();
		repeat (6) @(posedge clk);
		reset <= 1'b0;
	endtask : do_reset
	// notes the expected answer, issues the command, then updates the model
	task automatic op(input logic w, input logic r, input logic [5:0] a, input logic [7:0] d,
		input logic s);
		if (r && a == CVMR_REG_ADDR)
			q_rd.push_back({m_mode, m_rng[s], m_lvl[s]});
		ctrl_u.cmd(w, r, a, d);
		wsel <= s;
		if (w && a == CVMR_REG_ADDR && d[5:0] > CVMR_LEVEL_MAX)
			n_ref++;
		else if (w && a == CVMR_REG_ADDR) begin
			m_lvl[s] = d[5:0];
			m_rng[s] = d[6];
			m_mode = d[7];
		end
	endtask : op
	task automatic chk_op(input logic s);
		ctrl_u.cmd(1'b0, 1'b0, 6'h00, 8'h00);
		osel <= s;
		@(negedge clk);
		chk(lvl_o, m_lvl[s]);
		chk(rng_o, m_rng[s]);
		chk(tenths_o, (m_rng[s] ? CVMR_BASE_R1 : CVMR_BASE_R0) + 10'(CVMR_STEP) * m_lvl[s]);
		chk(mode_o, m_mode & bm_lat);
	endtask : chk_op
	////////////////////////////////////////////////////////////////////////////
	// output watcher: every answer is matched against the oldest note
	always @(negedge clk) begin
		if (reset === 1'b0) begin
			if (dq_oe === 1'b1) begin
				if (q_rd.size() > 0)
					chk(dq_out, q_rd.pop_front());
				else
					chk(dq_out, 16'hFFFF);
			end else
				chk(dq_out, CVMR_DQ_IDLE);
			if (mrw_refused === 1'b1) begin
				chk(16'(n_ref > 0), 16'h1);
				n_ref--;
			end
		end
	end
	initial begin
		repeat (5000) @(posedge clk);
		n_fail++;
		final_report();
	end
	initial begin
		logic [5:0] a;
		logic [7:0] d;
		logic s;
		reset = 1'b1;
		wsel = 1'b0;
		osel = 1'b0;
		byte_mode = 1'b1;
		void'($urandom(13));
		do_reset(1'b1);
		op(1'b0, 1'b1, CVMR_REG_ADDR, 8'h00, 1'b0);
		op(1'b0, 1'b1, CVMR_REG_ADDR, 8'h00, 1'b1);
		chk_op(1'b1);
		// back-to-back writes, same-slot reads, boundary and reserved codes
		for (int i = 0; i < 60; i++) begin
			a = ($urandom % 8 == 0) ? 6'h0D : CVMR_REG_ADDR;
			d = 8'($urandom);
			if (i < 3) begin
				a = CVMR_REG_ADDR;
				d[5:0] = 6'(6'h31 + i);
			end else if (d[5:0] > CVMR_LEVEL_MAX)
				d[5:0] = d[5:0] - 6'h20;
			s = 1'($urandom);
			op(1'b1, i[0], a, d, s);
			if (i % 4 == 3)
				chk_op(s ^ i[2]);
		end
		op(1'b0, 1'b1, CVMR_REG_ADDR, 8'h00, 1'b0);
		op(1'b0, 1'b1, CVMR_REG_ADDR, 8'h00, 1'b1);
		chk_op(1'b0);
		// reset in mid-run on a word-wide part: mode stored, not applied
		do_reset(1'b0);
		op(1'b1, 1'b0, CVMR_REG_ADDR, 8'hB2, 1'b1);
		op(1'b0, 1'b1, CVMR_REG_ADDR, 8'h00, 1'b1);
		chk_op(1'b1);
		chk_op(1'b0);
		repeat (4) ctrl_u.cmd(1'b0, 1'b0, 6'h00, 8'h00);
		@(negedge clk);
		chk(16'(n_ref + q_rd.size()), 16'h0);
		final_report();
	end
endmodule : tb_ca_vref_mode_register
